// File: src/irq_ctrl_pkg.sv
// Constants, types and helper functions shared by the interrupt controller files.
// Assumes a single 40 MHz system clock and an AHB-Lite register bus with 32-bit data.
package irq_ctrl_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL_FIRST = 8'h00;
    localparam logic [7:0] OFS_CTRL_SECOND = 8'h04;
    localparam logic [7:0] OFS_RTC_CTRL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;

    localparam int CF_MASTER = 0;
    localparam int CF_EXT0_EN = 1;
    localparam int CF_EXT1_EN = 2;
    localparam int CF_T0_EN = 3;
    localparam int CF_EXT0_FLAG = 4;
    localparam int CF_EXT1_FLAG = 5;
    localparam int CF_T0_FLAG = 6;
    localparam int CS_T1_EN = 0;
    localparam int CS_TB_EN = 1;
    localparam int CS_RTC_EN = 2;
    localparam int CS_T1_FLAG = 4;
    localparam int CS_TB_FLAG = 5;
    localparam int CS_RTC_FLAG = 6;
    localparam logic [2:0] RTC_SEL_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Sources, listed from highest to lowest priority
    // ------------------------------------------------------------------
    localparam int NUM_SRC = 6;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_EXT1 = 1;
    localparam int SRC_T0 = 2;
    localparam int SRC_T1 = 3;
    localparam int SRC_TB = 4;
    localparam int SRC_RTC = 5;
    localparam logic [7:0] VEC_EXT0 = 8'h04;
    localparam logic [7:0] VEC_EXT1 = 8'h08;
    localparam logic [7:0] VEC_T0 = 8'h0C;
    localparam logic [7:0] VEC_T1 = 8'h10;
    localparam logic [7:0] VEC_TB = 8'h14;
    localparam logic [7:0] VEC_RTC = 8'h18;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int WAKE_CYCLES = 1024;
    localparam logic [10:0] WAKE_LAST = 11'(WAKE_CYCLES - 1);
    localparam int RTC_BASE_LOG2 = 8;
    localparam int TB_LOG2_DEFAULT = 12;

    typedef enum logic [1:0] {FS_RTC_OSC, FS_WDT_OSC, FS_SYS_DIV4} fs_source_t;
    typedef enum logic [2:0] {ST_RUN = 3'b001, ST_SLEEP = 3'b010, ST_WARMUP = 3'b100} power_state_t;

    function automatic logic low_bits_full(logic [14:0] cnt, int unsigned n);
        logic [14:0] mask;
        mask = 15'((32'h1 << n) - 32'h1);
        return &(cnt | ~mask);
    endfunction

    function automatic logic [2:0] first_set(logic [NUM_SRC-1:0] req);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [7:0] vector_of(logic [2:0] idx);
        logic [7:0] v;
        v = VEC_EXT0;
        unique case (idx)
            3'h0: v = VEC_EXT0;
            3'h1: v = VEC_EXT1;
            3'h2: v = VEC_T0;
            3'h3: v = VEC_T1;
            3'h4: v = VEC_TB;
            3'h5: v = VEC_RTC;
            default: v = VEC_EXT0;
        endcase
        return v;
    endfunction

endpackage

// File: src/tick_if.sv
// Periodic time-out strobes and the RTC ratio select between the divider and the controller.
// Assumes both ends run on the system clock.
interface tick_if;
    logic timebase_tick;
    logic rtc_tick;
    logic [2:0] rtc_ratio_sel;
    modport source (output timebase_tick, output rtc_tick, input rtc_ratio_sel);
    modport sink (input timebase_tick, input rtc_tick, output rtc_ratio_sel);
endinterface

// File: src/fs_divider.sv
// The fs clock select and the divider chain behind the time base and RTC time-outs.
// Assumes the oscillator inputs are slow levels from other clock sources.
module fs_divider
    import irq_ctrl_pkg::*;
#(
    parameter fs_source_t FS_SOURCE = FS_SYS_DIV4,
    parameter bit SYSCLK_IS_RTC = 1'b0,
    parameter int TB_LOG2 = TB_LOG2_DEFAULT
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic rtc_osc_i,
    input wire logic wdt_osc_i,
    tick_if.source ticks
);

    typedef struct packed {
        logic [1:0] rtc_sync;
        logic [1:0] wdt_sync;
        logic [1:0] sys_div;
        logic fs_prev;
        logic [14:0] count;
        logic tb_tick;
        logic rtc_tick;
    } div_state_t;

    // With the system clock on the RTC oscillator, fs is forced to that oscillator too.
    localparam fs_source_t FS_EFFECTIVE = SYSCLK_IS_RTC ? FS_RTC_OSC : FS_SOURCE;

    div_state_t st_reg;
    div_state_t st_next;
    logic fs_level;
    logic fs_rise;

    always_comb begin
        unique case (FS_EFFECTIVE)
            FS_RTC_OSC: fs_level = st_reg.rtc_sync[1];
            FS_WDT_OSC: fs_level = st_reg.wdt_sync[1];
            FS_SYS_DIV4: fs_level = st_reg.sys_div[1];
            default: fs_level = st_reg.sys_div[1];
        endcase
        fs_rise = fs_level & ~st_reg.fs_prev;
        st_next = st_reg;
        st_next.rtc_sync = {st_reg.rtc_sync[0], rtc_osc_i};
        st_next.wdt_sync = {st_reg.wdt_sync[0], wdt_osc_i};
        st_next.sys_div = st_reg.sys_div + 2'h1;
        st_next.fs_prev = fs_level;
        st_next.tb_tick = fs_rise & low_bits_full(st_reg.count, TB_LOG2);
        st_next.rtc_tick = fs_rise & low_bits_full(st_reg.count, RTC_BASE_LOG2 + ticks.rtc_ratio_sel);
        if (fs_rise) begin
            st_next.count = st_reg.count + 15'h1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ticks.timebase_tick = st_reg.tb_tick;
    assign ticks.rtc_tick = st_reg.rtc_tick;

endmodule

// File: src/irq_controller.sv
// Interrupt controller: request flags, enables, fixed priority, vector call and power-down wake-up.
// Assumes an AHB-Lite master on sys_clk_i, and a core sequencer that drives the phase strobe,
// the stack-full level and the power-down level from logic on the same clock.
//
// What this block does
// - Service requests on the next phase-clock rise.
// - Priority: ext0, ext1, timer0, timer1, timebase, rtc.
// - External needs master, pin enable and flag.
// - External flag set on build-time chosen edge.
// - Pin is interrupt only when enabled and input.
// - External calls go to 04H or 08H.
// - External entry clears its flag and master.
// - Timer overflow sets flag; needs master and enable.
// - Timer calls go to 0CH or 10H.
// - Timer entry clears its flag and master.
// - Timebase enable bit 1, flag bit 5.
// - Timebase calls 014H and clears master.
// - Timebase period fs over two-to-12..15.
// - fs comes from one of three sources.
// - RTC enable bit 2, flag bit 6.
// - RTC calls 018H and clears master.
// - RTC period fs over programmable two-to-8..15.
// - RTC system clock forces fs from RTC.
// - Wait 1024 cycles after wake-up.
// - Flags stay set until serviced or cleared.
// - Any of the six sources wakes.
// - Only the program counter is pushed.
// - Full stack withholds every acknowledgement.
// - Flags still record while master is cleared.
module irq_controller
    import irq_ctrl_pkg::*;
#(
    parameter fs_source_t FS_SOURCE = FS_SYS_DIV4,
    parameter bit SYSCLK_IS_RTC = 1'b0,
    parameter int TB_LOG2 = TB_LOG2_DEFAULT,
    parameter bit EXT_RISING = 1'b0
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic ext0_pin_i,
    input wire logic ext1_pin_i,
    input wire logic [1:0] port_b_is_input_i,
    input wire logic timer0_overflow_i,
    input wire logic timer1_overflow_i,
    input wire logic rtc_osc_i,
    input wire logic wdt_osc_i,
    input wire logic instruction_phase_clock_i,
    input wire logic stack_full_i,
    input wire logic power_down_i,
    output logic irq_call_o,
    output logic push_pc_o,
    output irq_ctrl_pkg::power_state_t power_state_o,
    output logic [7:0] irq_vector_o,
    output logic core_hold_o
);
    import irq_ctrl_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic master_irq_enable;
        logic [NUM_SRC-1:0] irq_enable;
        logic [NUM_SRC-1:0] request_flag;
        logic [2:0] rtc_ratio_sel;
        logic [1:0] pin_sync_a;
        logic [1:0] pin_sync_b;
        logic [1:0] pin_prev;
        logic phase_prev;
        power_state_t power_state;
        logic [10:0] warm_count;
        logic call_pulse;
        logic [7:0] vector;
        logic wr_pending;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
    } ctrl_state_t;

    ctrl_state_t st_reg;
    ctrl_state_t st_next;
    tick_if ticks ();

    logic [NUM_SRC-1:0] events;
    logic [NUM_SRC-1:0] grantable;
    logic [1:0] pin_edge;
    logic phase_rise;
    logic take_irq;
    logic [2:0] winner;
    logic bus_access;
    logic [7:0] wdata_byte;

    fs_divider #(
        .FS_SOURCE(FS_SOURCE),
        .SYSCLK_IS_RTC(SYSCLK_IS_RTC),
        .TB_LOG2(TB_LOG2)
    ) u_fs_divider (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .rtc_osc_i(rtc_osc_i),
        .wdt_osc_i(wdt_osc_i),
        .ticks(ticks.source)
    );

    assign ticks.rtc_ratio_sel = st_reg.rtc_ratio_sel;

    // ------------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------------
    // The pin edge is taken from the second synchroniser stage and the flop behind it.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (EXT_RISING) begin
                pin_edge[i] = st_reg.pin_sync_b[i] & ~st_reg.pin_prev[i];
            end else begin
                pin_edge[i] = ~st_reg.pin_sync_b[i] & st_reg.pin_prev[i];
            end
        end
    end

    // A shared port line only reaches its flag while its enable is set and it is an input.
    assign events[SRC_EXT0] = pin_edge[0] & st_reg.irq_enable[SRC_EXT0] & port_b_is_input_i[0];
    assign events[SRC_EXT1] = pin_edge[1] & st_reg.irq_enable[SRC_EXT1] & port_b_is_input_i[1];
    assign events[SRC_T0] = timer0_overflow_i;
    assign events[SRC_T1] = timer1_overflow_i;
    assign events[SRC_TB] = ticks.timebase_tick;
    assign events[SRC_RTC] = ticks.rtc_tick;

    // ------------------------------------------------------------------
    // Grant
    // ------------------------------------------------------------------
    assign phase_rise = instruction_phase_clock_i & ~st_reg.phase_prev;
    assign grantable = st_reg.request_flag & st_reg.irq_enable & {NUM_SRC{st_reg.master_irq_enable}};
    assign winner = first_set(grantable);
    // Nothing is acknowledged while the stack is full or the core is asleep or warming up.
    assign take_irq = phase_rise & (|grantable) & ~stack_full_i & (st_reg.power_state == ST_RUN);

    assign bus_access = hsel_i & htrans_i[1] & hready_i;
    assign wdata_byte = hwdata_i[7:0];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.pin_sync_a = {ext1_pin_i, ext0_pin_i};
        st_next.pin_sync_b = st_reg.pin_sync_a;
        st_next.pin_prev = st_reg.pin_sync_b;
        st_next.phase_prev = instruction_phase_clock_i;
        st_next.call_pulse = take_irq;

        // Software write lands in the data phase, one cycle after the address phase.
        if (st_reg.wr_pending) begin
            unique case (st_reg.wr_addr)
                OFS_CTRL_FIRST: begin
                    st_next.master_irq_enable = wdata_byte[CF_MASTER];
                    st_next.irq_enable[SRC_EXT0] = wdata_byte[CF_EXT0_EN];
                    st_next.irq_enable[SRC_EXT1] = wdata_byte[CF_EXT1_EN];
                    st_next.irq_enable[SRC_T0] = wdata_byte[CF_T0_EN];
                    st_next.request_flag[SRC_EXT0] = wdata_byte[CF_EXT0_FLAG];
                    st_next.request_flag[SRC_EXT1] = wdata_byte[CF_EXT1_FLAG];
                    st_next.request_flag[SRC_T0] = wdata_byte[CF_T0_FLAG];
                end
                OFS_CTRL_SECOND: begin
                    st_next.irq_enable[SRC_T1] = wdata_byte[CS_T1_EN];
                    st_next.irq_enable[SRC_TB] = wdata_byte[CS_TB_EN];
                    st_next.irq_enable[SRC_RTC] = wdata_byte[CS_RTC_EN];
                    st_next.request_flag[SRC_T1] = wdata_byte[CS_T1_FLAG];
                    st_next.request_flag[SRC_TB] = wdata_byte[CS_TB_FLAG];
                    st_next.request_flag[SRC_RTC] = wdata_byte[CS_RTC_FLAG];
                end
                OFS_RTC_CTRL: begin
                    st_next.rtc_ratio_sel = wdata_byte[2:0];
                end
                default: begin
                end
            endcase
        end

        // Entry clears the winner's flag and the master enable; only the PC is pushed.
        if (take_irq) begin
            st_next.request_flag[winner] = 1'b0;
            st_next.master_irq_enable = 1'b0;
            st_next.vector = vector_of(winner);
        end

        // New events are recorded last, so they win over any clear in the same cycle.
        st_next.request_flag = st_next.request_flag | events;

        unique case (st_reg.power_state)
            ST_RUN: begin
                if (power_down_i) begin
                    st_next.power_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (|events) begin
                    st_next.power_state = ST_WARMUP;
                    st_next.warm_count = 11'h000;
                end
            end
            ST_WARMUP: begin
                if (st_reg.warm_count == WAKE_LAST) begin
                    st_next.power_state = ST_RUN;
                end else begin
                    st_next.warm_count = st_reg.warm_count + 11'h001;
                end
            end
            default: begin
                st_next.power_state = ST_RUN;
            end
        endcase

        st_next.wr_pending = bus_access & hwrite_i;
        if (bus_access) begin
            st_next.wr_addr = haddr_i[7:0];
        end
        st_next.rdata = 32'h0000_0000;
        if (bus_access & ~hwrite_i) begin
            unique case (haddr_i[7:0])
                OFS_CTRL_FIRST: begin
                    st_next.rdata[CF_MASTER] = st_reg.master_irq_enable;
                    st_next.rdata[CF_EXT0_EN] = st_reg.irq_enable[SRC_EXT0];
                    st_next.rdata[CF_EXT1_EN] = st_reg.irq_enable[SRC_EXT1];
                    st_next.rdata[CF_T0_EN] = st_reg.irq_enable[SRC_T0];
                    st_next.rdata[CF_EXT0_FLAG] = st_reg.request_flag[SRC_EXT0];
                    st_next.rdata[CF_EXT1_FLAG] = st_reg.request_flag[SRC_EXT1];
                    st_next.rdata[CF_T0_FLAG] = st_reg.request_flag[SRC_T0];
                end
                OFS_CTRL_SECOND: begin
                    st_next.rdata[CS_T1_EN] = st_reg.irq_enable[SRC_T1];
                    st_next.rdata[CS_TB_EN] = st_reg.irq_enable[SRC_TB];
                    st_next.rdata[CS_RTC_EN] = st_reg.irq_enable[SRC_RTC];
                    st_next.rdata[CS_T1_FLAG] = st_reg.request_flag[SRC_T1];
                    st_next.rdata[CS_TB_FLAG] = st_reg.request_flag[SRC_TB];
                    st_next.rdata[CS_RTC_FLAG] = st_reg.request_flag[SRC_RTC];
                end
                OFS_RTC_CTRL: begin
                    st_next.rdata[2:0] = st_reg.rtc_ratio_sel;
                end
                OFS_STATUS: begin
                    st_next.rdata[2:0] = st_reg.power_state;
                    st_next.rdata[15:8] = st_reg.vector;
                    st_next.rdata[26:16] = st_reg.warm_count;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
            st_reg.power_state <= ST_RUN;
            st_reg.rtc_ratio_sel <= RTC_SEL_RESET;
            // The pin chain starts at the idle level, so that leaving reset is never taken as a pin edge.
            st_reg.pin_sync_a <= {2{~EXT_RISING}};
            st_reg.pin_sync_b <= {2{~EXT_RISING}};
            st_reg.pin_prev <= {2{~EXT_RISING}};
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The slave never inserts wait states, so the bus sees hready high at all times.
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = st_reg.rdata;
    assign irq_call_o = st_reg.call_pulse;
    assign push_pc_o = st_reg.call_pulse;
    assign irq_vector_o = st_reg.vector;
    assign power_state_o = st_reg.power_state;
    assign core_hold_o = (st_reg.power_state != ST_RUN);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_phase_service: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        st_reg.call_pulse |-> $past(phase_rise))
        else $error("Call issued without a phase clock rise.");

    chk_priority_order: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_reg.call_pulse && st_reg.vector == VEC_EXT1) |-> !$past(grantable[SRC_EXT0]))
        else $error("Lower priority source won over external 0.");

    chk_ext_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_reg.call_pulse && st_reg.vector == VEC_EXT0) |->
        $past(st_reg.master_irq_enable & st_reg.irq_enable[SRC_EXT0] & st_reg.request_flag[SRC_EXT0]))
        else $error("External 0 taken without its enables and flag.");

    chk_stack_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        stack_full_i |=> !st_reg.call_pulse)
        else $error("Interrupt acknowledged with a full stack.");

    chk_master_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        st_reg.call_pulse |-> !st_reg.master_irq_enable)
        else $error("Master enable still set after entry.");

    chk_timer_flag_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_reg.call_pulse && st_reg.vector == VEC_T0 && !$past(events[SRC_T0])) |->
        !st_reg.request_flag[SRC_T0])
        else $error("Timer 0 flag not cleared on entry.");

    chk_rtc_vector: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_reg.call_pulse && st_reg.vector == VEC_RTC) |->
        $past(st_reg.request_flag[SRC_RTC] & st_reg.irq_enable[SRC_RTC] & ~(|grantable[SRC_TB:SRC_EXT0])))
        else $error("RTC vector without a winning RTC request.");

    chk_wake_event: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_reg.power_state == ST_SLEEP && (|events)) |=> st_reg.power_state == ST_WARMUP)
        else $error("Event in power-down did not start the wake-up.");

    chk_warmup_len: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $fell(st_reg.power_state == ST_WARMUP) |-> $past(st_reg.warm_count) == WAKE_LAST)
        else $error("Wake-up wait left early.");

    chk_flag_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (!take_irq && !st_reg.wr_pending) |=> ((st_reg.request_flag & $past(st_reg.request_flag)) ==
        $past(st_reg.request_flag)))
        else $error("Request flag dropped without service or write.");

    chk_ext_flag_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_reg.call_pulse && st_reg.vector == VEC_EXT0 && !$past(events[SRC_EXT0])) |->
        !st_reg.request_flag[SRC_EXT0])
        else $error("External 0 flag not cleared on entry.");

    chk_event_record: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        events[SRC_T1] |=> st_reg.request_flag[SRC_T1])
        else $error("Timer 1 event not recorded in its flag.");

    chk_hold_no_call: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_reg.power_state != ST_RUN) |=> !st_reg.call_pulse)
        else $error("Call issued while the core is held.");

    chk_pin_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (!port_b_is_input_i[1] && !st_reg.request_flag[SRC_EXT1] && !st_reg.wr_pending) |=>
        !st_reg.request_flag[SRC_EXT1])
        else $error("External 1 flag set while its line is not an input.");

endmodule

// File: testbench/core_model.sv
// Behavioural core sequencer facing the interrupt controller: phase strobe, stack-full and power-down.
// Assumes the bench asks for stack-full and power-down on the system clock.
module core_model (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic core_hold_i,
    input wire logic full_req_i,
    input wire logic sleep_req_i,
    output logic phase_o,
    output logic stack_full_o,
    output logic power_down_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_reg;

    // The phase strobe stops while the core is held, as a stalled core issues no instructions.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_reg <= 2'h0;
            phase_o <= 1'b0;
            stack_full_o <= 1'b0;
            power_down_o <= 1'b0;
        end else begin
            if (!core_hold_i) begin
                cnt_reg <= cnt_reg + 2'h1;
            end
            phase_o <= (cnt_reg == 2'h3) && !core_hold_i;
            stack_full_o <= full_req_i;
            power_down_o <= sleep_req_i;
        end
    end
endmodule

// File: testbench/irq_controller_bench.sv
// Self-checking bench for the interrupt controller, register access over AHB-Lite.
// Assumes the default build: fs from the system clock over four, falling-edge pins.
module irq_controller_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import irq_ctrl_pkg::*;
    logic sys_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, ext0 = 1'b1, ext1 = 1'b1;
    logic t0 = 1'b0, t1 = 1'b0, full_req = 1'b0, sleep_req = 1'b0, rd_dp = 1'b0;
    logic [1:0] htrans = 2'h0, port_in = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic hready, hresp, call, push, phase, full, pdn, hold;
    power_state_t pstate;
    logic [7:0] vec;
    logic [31:0] exp_rd[$];
    logic [7:0] exp_vec[$];
    logic [7:0] vt[6] = '{VEC_EXT0, VEC_EXT1, VEC_T0, VEC_T1, VEC_TB, VEC_RTC};
    int miscompares = 0, n_checks = 0, seed = 6, n;
    logic [5:0] f;
    logic [2:0] r;

    irq_controller dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .ext0_pin_i(ext0), .ext1_pin_i(ext1),
        .port_b_is_input_i(port_in), .timer0_overflow_i(t0), .timer1_overflow_i(t1), .rtc_osc_i(1'b0),
        .wdt_osc_i(1'b0), .instruction_phase_clock_i(phase), .stack_full_i(full), .power_down_i(pdn),
        .irq_call_o(call), .push_pc_o(push), .power_state_o(pstate), .irq_vector_o(vec), .core_hold_o(hold));
    core_model core (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .core_hold_i(hold), .full_req_i(full_req),
        .sleep_req_i(sleep_req), .phase_o(phase), .stack_full_o(full), .power_down_o(pdn));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic conclude;
        if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsel <= 1'b1;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        rd_dp <= !w;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        rd_dp <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // ------------------------------------------------------------------
    // Output watcher and clocks
    // ------------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rd_dp === 1'b1) begin
            cmp(hrdata, exp_rd.pop_front());
            cmp({31'h0, hresp}, 32'h0);
        end
        if (call === 1'b1) begin
            // A call with nothing expected is reported as a mismatch.
            if (exp_vec.size() == 0) cmp(32'h1, 32'h0);
            else cmp({24'h0, vec}, {24'h0, exp_vec.pop_front()});
            cmp({31'h0, push}, 32'h1);
        end
    end
    initial forever #12.5 sys_clk = ~sys_clk;
    initial begin
        #500000;
        miscompares++;
        conclude();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h0C, 32'h1);
        rd(8'h10, 32'h0);
        r = 3'($random(seed));
        bus(1'b1, 8'h08, {29'h0, r});
        rd(8'h08, {29'h0, r});
        bus(1'b1, 8'h04, 32'h77);
        f = 6'h3F;
        // All six flags pending: each master re-enable must take the next source down the order.
        for (int i = 0; i < 6; i++) begin
            exp_vec.push_back(vt[i]);
            bus(1'b1, 8'h00, {25'h0, f[2:0], 4'hF});
            repeat (10) @(posedge sys_clk);
            f[i] = 1'b0;
        end
        rd(8'h0C, 32'h0000_1801);
        bus(1'b1, 8'h04, 32'h0);
        rd(8'h00, 32'h0E);
        t0 <= 1'b1;
        @(posedge sys_clk);
        t0 <= 1'b0;
        repeat (10) @(posedge sys_clk);
        rd(8'h00, 32'h4E);
        bus(1'b1, 8'h00, 32'h40);
        rd(8'h00, 32'h40);
        full_req <= 1'b1;
        bus(1'b1, 8'h00, 32'h49);
        repeat (12) @(posedge sys_clk);
        exp_vec.push_back(VEC_T0);
        full_req <= 1'b0;
        repeat (12) @(posedge sys_clk);
        rd(8'h00, 32'h08);
        port_in <= 2'b01;
        bus(1'b1, 8'h00, 32'h06);
        ext0 <= 1'b0;
        ext1 <= 1'b0;
        repeat (10) @(posedge sys_clk);
        rd(8'h00, 32'h16);
        sleep_req <= 1'b1;
        @(posedge sys_clk);
        sleep_req <= 1'b0;
        repeat (4) @(negedge sys_clk);
        cmp({29'h0, pstate}, {29'h0, ST_SLEEP});
        cmp({31'h0, hold}, 32'h1);
        @(posedge sys_clk);
        t1 <= 1'b1;
        @(posedge sys_clk);
        t1 <= 1'b0;
        n = 0;
        repeat (1200) begin
            @(negedge sys_clk);
            if (pstate === ST_WARMUP) n++;
        end
        cmp(32'(n), 32'h400);
        cmp({31'h0, hold}, 32'h0);
        @(posedge sys_clk);
        rd(8'h0C, 32'h03FF_0C01);
        @(posedge sys_clk);
        conclude();
    end
endmodule
